/* mrlh_map.svh */
// register offsets, field positions and reset values of the mode, reset and limp home controller
// assumes a 32-bit AXI4-Lite data path, one aligned word per register
`ifndef MRLH_MAP_SVH
`define MRLH_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MRLH_OFS_CMD       8'h00
`define MRLH_OFS_CHAN      8'h04
`define MRLH_OFS_STATUS    8'h08
`define MRLH_OFS_IRQ_STAT  8'h0c
`define MRLH_OFS_IRQ_MASK  8'h10

// ****************************************************************
// command bits, written as one
// ****************************************************************
`define MRLH_CMD_WAKE      0
`define MRLH_CMD_STANDBY   1
`define MRLH_CMD_RESET     2

// ****************************************************************
// status word, also the standard diagnostic frame
// ****************************************************************
`define MRLH_ST_MODE_LSB   0
`define MRLH_ST_LIMP       3
`define MRLH_ST_UV         4
`define MRLH_ST_LOGIC_LOW  5
`define MRLH_ST_TER        7
`define MRLH_ST_CHAN_LSB   8

// ****************************************************************
// event bits of the interrupt status and mask
// ****************************************************************
`define MRLH_EV_RESET      0
`define MRLH_EV_LIMP_IN    1
`define MRLH_EV_LIMP_OUT   2
`define MRLH_EV_UV         3
`define MRLH_EV_W          4

// ****************************************************************
// channel positions and reset values
// ****************************************************************
`define MRLH_CH4_BIT       3
`define MRLH_CH5_BIT       4
`define MRLH_CHAN_RST      8'h00
`define MRLH_MASK_RST      4'h0
`define MRLH_TER_RST       1'b1
`define MRLH_RESP_OKAY     2'b00
`define MRLH_RESP_SLVERR   2'b10

`endif

/* mrlh_pkg.sv */
// types shared by the mode, reset and limp home controller
// assumes the offsets and fields in mrlh_map.svh
package mrlh_pkg;

  // ****************************************************************
  // operating modes, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_SLEEP  = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_LIMP   = 3'b100
  } mrlh_mode_e;

endpackage : mrlh_pkg

/* mrlh_sync.sv */
// two flip-flop synchroniser for a group of unrelated pin levels
// assumes each bit is a slow level; no bit carries a word
`timescale 1ns/100ps

module mrlh_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,    // system clock
  input  wire logic         aresetn, // synchronous reset, active low
  input  wire logic [W-1:0] d,       // asynchronous levels
  output logic      [W-1:0] q        // synchronised levels
);

  logic [W-1:0] meta;

  // the first stage feeds the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : mrlh_sync

/* mrlh_ctrl.sv */
// mode, reset and limp home controller of an eight-channel relay switch, AXI4-Lite register slave
// assumes supply monitors and the limp home and control pins arrive asynchronously
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "mrlh_map.svh"

module mrlh_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,               // system clock, 250 MHz
  input  wire logic              aresetn,            // synchronous reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,             // write address
  input  wire logic              awvalid,            // write address valid
  output logic                   awready,            // write address ready
  input  wire logic [31:0]       wdata,              // write data
  input  wire logic [3:0]        wstrb,              // write byte strobes
  input  wire logic              wvalid,             // write data valid
  output logic                   wready,             // write data ready
  output logic [1:0]             bresp,              // write response
  output logic                   bvalid,             // write response valid
  input  wire logic              bready,             // write response ready
  input  wire logic [ADDR_W-1:0] araddr,             // read address
  input  wire logic              arvalid,            // read address valid
  output logic                   arready,            // read address ready
  output logic [31:0]            rdata,              // read data
  output logic [1:0]             rresp,              // read response
  output logic                   rvalid,             // read data valid
  input  wire logic              rready,             // read data ready
  input  wire logic              battery_supply_ok,  // battery supply above undervoltage threshold
  input  wire logic              logic_supply_ok,    // logic supply above undervoltage threshold
  input  wire logic              limp_home_input,    // fail-safe request pin
  input  wire logic              ctrl_in1,           // control input pin one
  input  wire logic              ctrl_in2,           // control input pin two
  output logic [7:0]             channel_out,        // channel on commands, bit 0 is channel 1
  output logic [2:0]             mode,               // one-hot operating mode
  output logic                   transmission_error_flag, // a reset has happened
  output logic                   irq                 // level interrupt
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (ADDR_W < 8) begin : g_addr_check
    $error("mrlh_ctrl: ADDR_W must be at least 8");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic       batt_s;
  logic       logic_s;
  logic       limp_s;
  logic       in1_s;
  logic       in2_s;

  mrlh_sync #(
    .W (5)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({ctrl_in2, ctrl_in1, limp_home_input, logic_supply_ok, battery_supply_ok}),
    .q       ({in2_s, in1_s, limp_s, logic_s, batt_s})
  );

  // ****************************************************************
  // functions
  // ****************************************************************
  // 0 = command, 1 = channels, 2 = status, 3 = irq status, 4 = irq mask, 7 = unmapped
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    // a shift instead of a part-select keeps the default eight-bit address legal
    if ((a >> 8) != '0) begin
      reg_sel = 3'h7;
    end else if (lo == `MRLH_OFS_CMD) begin
      reg_sel = 3'h0;
    end else if (lo == `MRLH_OFS_CHAN) begin
      reg_sel = 3'h1;
    end else if (lo == `MRLH_OFS_STATUS) begin
      reg_sel = 3'h2;
    end else if (lo == `MRLH_OFS_IRQ_STAT) begin
      reg_sel = 3'h3;
    end else if (lo == `MRLH_OFS_IRQ_MASK) begin
      reg_sel = 3'h4;
    end else begin
      reg_sel = 3'h7;
    end
  endfunction : reg_sel

  // ****************************************************************
  // state
  // ****************************************************************
  mrlh_pkg::mrlh_mode_e           cur_mode;
  mrlh_pkg::mrlh_mode_e           next_mode;
  logic [7:0]                     chan_cfg;
  logic [`MRLH_EV_W-1:0]          irq_stat;
  logic [`MRLH_EV_W-1:0]          irq_mask;
  logic                           uv_q;
  logic                           aw_full;
  logic                           w_full;
  logic [ADDR_W-1:0]              aw_addr;
  logic [31:0]                    w_data;
  logic [3:0]                     w_strb;

  // ****************************************************************
  // supply and bus qualification
  // ****************************************************************
  logic       uv;
  logic       uv_rise;
  logic       bus_ok;
  logic       wr_fire;
  logic       ar_fire;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;

  assign uv      = !batt_s;
  assign uv_rise = uv && !uv_q;
  // commands need the logic supply, no reset and no limp home
  assign bus_ok  = logic_s && !uv && (cur_mode != mrlh_pkg::MODE_LIMP);
  assign wr_fire = aw_full && w_full && !bvalid;
  assign ar_fire = arvalid && arready;
  assign wr_sel  = reg_sel(aw_addr);
  assign rd_sel  = reg_sel(araddr);

  // ****************************************************************
  // commands and reset sources
  // ****************************************************************
  logic cmd_wr;
  logic cmd_wake;
  logic standby_command_bit;
  logic cmd_rst;
  logic limp_entry;
  logic limp_exit;
  logic sleep_entry;
  logic any_reset;
  logic clr_regs;

  assign cmd_wr     = wr_fire && bus_ok && (wr_sel == 3'h0) && w_strb[0];
  assign cmd_wake   = cmd_wr && w_data[`MRLH_CMD_WAKE];
  assign standby_command_bit    = cmd_wr && w_data[`MRLH_CMD_STANDBY];
  assign cmd_rst    = cmd_wr && w_data[`MRLH_CMD_RESET];
  assign limp_entry = (next_mode == mrlh_pkg::MODE_LIMP) && (cur_mode != mrlh_pkg::MODE_LIMP);
  assign limp_exit  = (cur_mode == mrlh_pkg::MODE_LIMP) && (next_mode != mrlh_pkg::MODE_LIMP);
  assign sleep_entry = (next_mode == mrlh_pkg::MODE_SLEEP) && (cur_mode != mrlh_pkg::MODE_SLEEP);
  // each reset source fires once; a held undervoltage keeps the registers cleared below
  assign any_reset  = uv_rise || cmd_rst || limp_entry;
  // limp home holds the write registers at default for its whole span
  assign clr_regs   = uv || cmd_rst || sleep_entry ||
                      (next_mode == mrlh_pkg::MODE_LIMP);

  // ****************************************************************
  // mode machine
  // ****************************************************************
  always_comb begin
    next_mode = cur_mode;
    case (cur_mode)
      mrlh_pkg::MODE_SLEEP: begin
        if (limp_s) begin
          next_mode = mrlh_pkg::MODE_LIMP;
        end else if (cmd_wake) begin
          next_mode = mrlh_pkg::MODE_NORMAL;
        end
      end
      mrlh_pkg::MODE_NORMAL: begin
        if (limp_s) begin
          next_mode = mrlh_pkg::MODE_LIMP;
        end else if (standby_command_bit) begin
          next_mode = mrlh_pkg::MODE_SLEEP;
        end
      end
      mrlh_pkg::MODE_LIMP: begin
        // no logic supply term here: limp home runs on the battery alone
        if (!limp_s) begin
          next_mode = mrlh_pkg::MODE_SLEEP;
        end
      end
      default: begin
        next_mode = mrlh_pkg::MODE_SLEEP;
      end
    endcase
    // undervoltage and the reset command leave the device in its power-on mode
    if (uv || cmd_rst) begin
      next_mode = mrlh_pkg::MODE_SLEEP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_mode <= mrlh_pkg::MODE_SLEEP;
    end else begin
      cur_mode <= next_mode;
    end
  end

  always_ff @(posedge aclk) begin
    // the synchroniser shows undervoltage until it has filled; starting high hides that false onset
    if (!aresetn) begin
      uv_q <= 1'b1;
    end else begin
      uv_q <= uv;
    end
  end

  // ****************************************************************
  // write registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_regs) begin
      chan_cfg <= `MRLH_CHAN_RST;
    end else if (wr_fire && bus_ok && (wr_sel == 3'h1) && w_strb[0]) begin
      chan_cfg <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clr_regs) begin
      irq_mask <= `MRLH_MASK_RST;
    end else if (wr_fire && bus_ok && (wr_sel == 3'h4) && w_strb[0]) begin
      irq_mask <= w_data[`MRLH_EV_W-1:0];
    end
  end

  // ****************************************************************
  // sticky events, cleared by writing one; a new event wins
  // ****************************************************************
  logic [`MRLH_EV_W-1:0] ev;
  logic [`MRLH_EV_W-1:0] ev_clr;

  assign ev = {uv_rise, limp_exit, limp_entry, any_reset};
  // clearing is a bus write gated by the logic supply alone, so it stays possible in limp home and undervoltage
  assign ev_clr = (wr_fire && logic_s && (wr_sel == 3'h3) && w_strb[0]) ?
                  w_data[`MRLH_EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~ev_clr) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // transmission error flag, cleared by reading the status word
  // ****************************************************************
  logic ter_clr;

  assign ter_clr = ar_fire && (rd_sel == 3'h2) && !uv && logic_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmission_error_flag <= `MRLH_TER_RST;
    end else if (any_reset || uv) begin
      transmission_error_flag <= 1'b1;
    end else if (ter_clr) begin
      transmission_error_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // channel drive
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || uv || cmd_rst) begin
      channel_out <= 8'h00;
    end else begin
      channel_out <= 8'h00;
      case (next_mode)
        mrlh_pkg::MODE_NORMAL: begin
          // independent of the logic supply, so cranking and a lost port keep the state
          channel_out <= chan_cfg;
        end
        mrlh_pkg::MODE_LIMP: begin
          channel_out[`MRLH_CH4_BIT] <= in1_s;
          channel_out[`MRLH_CH5_BIT] <= in2_s;
        end
        default: begin
          channel_out <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= mrlh_pkg::MODE_SLEEP;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************************************
  // status word, which is also the diagnostic frame
  // ****************************************************************
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`MRLH_ST_MODE_LSB +: 3] = cur_mode;
    status_word[`MRLH_ST_LIMP]          = limp_s;
    status_word[`MRLH_ST_UV]            = uv;
    status_word[`MRLH_ST_LOGIC_LOW]     = !logic_s;
    status_word[`MRLH_ST_TER]           = transmission_error_flag || uv;
    status_word[`MRLH_ST_CHAN_LSB +: 8] = channel_out;
  end

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // writes that are dropped for supply or limp home still answer okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `MRLH_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (wr_sel == 3'h7 || wr_sel == 3'h2) ? `MRLH_RESP_SLVERR : `MRLH_RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
    end else if (ar_fire) begin
      arready <= 1'b0;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `MRLH_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rresp  <= `MRLH_RESP_OKAY;
      if (uv || !logic_s) begin
        rdata <= status_word;
      end else if (rd_sel == 3'h1) begin
        rdata <= {24'h00_0000, chan_cfg};
      end else if (rd_sel == 3'h2) begin
        rdata <= status_word;
      end else if (rd_sel == 3'h3) begin
        rdata <= {{(32-`MRLH_EV_W){1'b0}}, irq_stat};
      end else if (rd_sel == 3'h4) begin
        rdata <= {{(32-`MRLH_EV_W){1'b0}}, irq_mask};
      end else if (rd_sel == 3'h0) begin
        rdata <= 32'h0000_0000;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `MRLH_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : mrlh_ctrl

/* mrlh_ctrl_checker.sv */
// port assertions for the mode, reset and limp home controller
// assumes it is bound onto mrlh_ctrl and sees only its ports
`timescale 1ns/100ps

module mrlh_ctrl_checker (
  input wire logic        aclk,                    // clock
  input wire logic        aresetn,                 // reset, active low
  input wire logic        bvalid,                  // write response valid
  input wire logic        rvalid,                  // read valid
  input wire logic [31:0] rdata,                   // read data
  input wire logic        battery_supply_ok,       // battery above threshold
  input wire logic        limp_home_input,         // limp home pin
  input wire logic        ctrl_in1,                // control pin one
  input wire logic        ctrl_in2,                // control pin two
  input wire logic [7:0]  channel_out,             // channel commands
  input wire logic [2:0]  mode,                    // one-hot mode
  input wire logic        transmission_error_flag  // reset seen
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************************************
  // pins pass two flops, so pin causes are looked for three edges back
  // ****************************************************************
  chk_limp_enter: assert property ($rose(mode[2]) |-> $past(limp_home_input, 3))
    else $error("limp mode without limp pin");
  chk_limp_route: assert property ((mode[2] && $stable(ctrl_in1) && $stable(ctrl_in2))[*4] |->
    channel_out[4:3] == {ctrl_in2, ctrl_in1}) else $error("limp routing wrong");
  chk_limp_other: assert property (mode[2] |-> {channel_out[7:5], channel_out[2:0]} == 6'h00)
    else $error("channel on in limp");
  chk_limp_exit: assert property ($fell(mode[2]) |-> mode == 3'b001)
    else $error("limp exit not to sleep");
  chk_wake_write: assert property ($rose(mode[1]) |-> $rose(bvalid))
    else $error("operation entered without write");
  chk_sleep_off: assert property (mode == 3'b001 |-> channel_out == 8'h00)
    else $error("channel on in sleep");
  chk_uv_reset: assert property ((!battery_supply_ok)[*5] |->
    mode == 3'b001 && channel_out == 8'h00 && transmission_error_flag) else $error("undervoltage not reset");
  chk_uv_frame: assert property ((!battery_supply_ok)[*6] ##0 rvalid |-> rdata[7])
    else $error("undervoltage read lacks error flag");
endmodule : mrlh_ctrl_checker

bind mrlh_ctrl mrlh_ctrl_checker chk_u (.*);

/* mrlh_host.sv */
// host model: AXI4-Lite master making single-word transfers
// assumes the controller slave on the same clock; the bench bounds every wait
`timescale 1ns/100ps

module mrlh_host (
  input  wire logic        aclk,     // clock
  output logic [7:0]       awaddr,   // write address
  output logic             awvalid,  // write address valid
  input  wire logic        awready,  // write address ready
  output logic [31:0]      wdata,    // write data
  output logic [3:0]       wstrb,    // byte strobes
  output logic             wvalid,   // write data valid
  input  wire logic        wready,   // write data ready
  input  wire logic [1:0]  bresp,    // write response
  input  wire logic        bvalid,   // write response valid
  output logic             bready,   // write response ready
  output logic [7:0]       araddr,   // read address
  output logic             arvalid,  // read address valid
  input  wire logic        arready,  // read address ready
  input  wire logic [31:0] rdata,    // read data
  input  wire logic        rvalid,   // read valid
  output logic             rready    // read ready
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  assign wstrb = 4'hf;

  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dd;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dd);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dd = rdata;
    rready <= 1'b0;
  endtask : rd
endmodule : mrlh_host

/* mode_reset_limp_home_control_tb_top.sv */
// self-checking bench for the mode, reset and limp home controller
// assumes mrlh_ctrl, mrlh_host and the bound checker
`timescale 1ns/100ps
`include "mrlh_map.svh"

module mode_reset_limp_home_control_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, irq, transmission_error_flag, battery_supply_ok, logic_supply_ok;
  logic        limp_home_input, ctrl_in1, ctrl_in2;
  logic [7:0]  awaddr, araddr, channel_out, v;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  mode;
  int          seed = 32'hf636;
  int          miscompares = 0;
  int          checked = 0;

  mrlh_ctrl dut_u (.*);
  mrlh_host host_u (.*);

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic w(input int n); repeat (n) @(posedge aclk); endtask : w
  task automatic wr(input logic [7:0] a, input logic [31:0] dd); host_u.wr(a, dd, r); endtask : wr
  task automatic rd(input logic [7:0] a); host_u.rd(a, d); endtask : rd
  function automatic logic [7:0] route(input logic a, input logic b);
    return {3'b000, b, a, 3'b000};
  endfunction : route

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // the whole run needs about two hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    {aresetn, limp_home_input, ctrl_in1, ctrl_in2} = 4'h0;
    {battery_supply_ok, logic_supply_ok} = 2'b11;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    w(3);
    chk("mode", mode, 3'b001);
    rd(`MRLH_OFS_STATUS);
    chk("ter", d[7], 1'b1);
    wr(8'h20, 32'h0);
    chk("unmapped", r, `MRLH_RESP_SLVERR);
    rd(8'h20);
    chk("unmapped rd", rresp, `MRLH_RESP_SLVERR);
    repeat (2) begin
      v = 8'($random(seed));
      wr(`MRLH_OFS_CMD, 32'h1);
      chk("wake", mode, 3'b010);
      wr(`MRLH_OFS_CHAN, {24'h0, v});
      // the channel drive follows the stored configuration one edge later
      w(1);
      chk("chan", channel_out, v);
      logic_supply_ok <= 1'b0;
      w(3);
      wr(`MRLH_OFS_CMD, 32'h2);
      chk("held", channel_out, v);
      logic_supply_ok <= 1'b1;
      w(3);
      wr(`MRLH_OFS_CMD, 32'h2);
      chk("sleep", channel_out, 8'h00);
    end
    wr(`MRLH_OFS_CMD, 32'h1);
    wr(`MRLH_OFS_CHAN, 32'hff);
    wr(`MRLH_OFS_CMD, 32'h4);
    chk("rst chan", channel_out, 8'h00);
    chk("rst ter", transmission_error_flag, 1'b1);
    wr(`MRLH_OFS_IRQ_MASK, 32'h1);
    w(2);
    chk("irq", irq, 1'b1);
    wr(`MRLH_OFS_IRQ_STAT, 32'hf);
    w(2);
    chk("irq clear", irq, 1'b0);
    // first pass starts asleep with no logic supply, second from operation
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(`MRLH_OFS_CMD, 32'h1);
      if (k == 1) wr(`MRLH_OFS_CHAN, 32'hff);
      logic_supply_ok <= k[0];
      limp_home_input <= 1'b1;
      w(4);
      chk("limp", mode, 3'b100);
      repeat (3) begin
        {ctrl_in2, ctrl_in1} <= 2'($random(seed));
        w(4);
        chk("route", channel_out, route(ctrl_in1, ctrl_in2));
      end
      wr(`MRLH_OFS_CMD, 32'h2);
      chk("ignored", mode, 3'b100);
      rd(`MRLH_OFS_STATUS);
      chk("limp bit", d[3], 1'b1);
      limp_home_input <= 1'b0;
      logic_supply_ok <= 1'b1;
      w(4);
      chk("limp exit", mode, 3'b001);
    end
    wr(`MRLH_OFS_CMD, 32'h1);
    battery_supply_ok <= 1'b0;
    w(4);
    chk("uv ter", transmission_error_flag, 1'b1);
    rd(`MRLH_OFS_STATUS);
    chk("uv frame", d[7], 1'b1);
    wr(`MRLH_OFS_CMD, 32'h1);
    chk("uv hold", mode, 3'b001);
    battery_supply_ok <= 1'b1;
    w(4);
    wr(`MRLH_OFS_CMD, 32'h1);
    chk("uv release", mode, 3'b010);
    print_verdict();
  end
endmodule : mode_reset_limp_home_control_tb_top
